// ===== bench/omie_core_sva.sv
// concurrent checks on the executor ports
`timescale 1ns/10ps
module omie_core_chk
   import omie_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // instruction side
   input wire logic [INSTR_W-1:0] instrWord,
   input wire logic instrValid,
   input wire logic instrReady,
   input wire logic instrDone,
   input wire logic unknownOp,
   // results
   input wire logic [DATA_W-1:0] accumulator,
   input wire logic zeroFlag,
   input wire logic fileWrEn,
   input wire logic [FILE_ADDR_W-1:0] fileWrAddr,
   input wire logic [DATA_W-1:0] fileWrData
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic take, isOr, isMov, isLit, isSto, d;
   logic [DATA_W-1:0] litVal;
   logic [FILE_ADDR_W-1:0] fAddr;
   assign take = instrValid && instrReady;
   assign isOr = take && instrWord[13:8] == OPC_OR_FILE;
   assign isMov = take && instrWord[13:8] == OPC_MOVE_FILE;
   assign isLit = take && instrWord[13:10] == OPC_LOAD_LIT;
   assign isSto = take && instrWord[13:7] == OPC_STORE_ACC;
   assign d = instrWord[DEST_BIT];
   assign litVal = instrWord[LIT_MSB:0];
   assign fAddr = instrWord[FILE_ADDR_MSB:0];
   property p_done_time;
      take |=> !instrReady ##1 instrDone;
   endproperty
   a_done_time: assert property (p_done_time) else $error("done late");
   property p_done_cause;
      instrDone |-> $past(take, 2);
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done without word");
   property p_lit;
      isLit |=> ##1 accumulator == $past(litVal, 2) && zeroFlag == $past(zeroFlag, 2) && !fileWrEn;
   endproperty
   a_lit: assert property (p_lit) else $error("literal load wrong");
   property p_store;
      isSto |=> ##1 fileWrEn && fileWrAddr == $past(fAddr, 2) && fileWrData == accumulator
         && zeroFlag == $past(zeroFlag, 2);
   endproperty
   a_store: assert property (p_store) else $error("store wrong");
   property p_or_acc;
      isOr && !d |=> ##1 (accumulator & $past(accumulator, 2)) == $past(accumulator, 2)
         && zeroFlag == (accumulator == 8'h00) && !fileWrEn;
   endproperty
   a_or_acc: assert property (p_or_acc) else $error("or to acc wrong");
   property p_or_file;
      isOr && d |=> ##1 fileWrEn && fileWrAddr == $past(fAddr, 2) && accumulator == $past(accumulator, 2)
         && (fileWrData & accumulator) == accumulator && zeroFlag == (fileWrData == 8'h00);
   endproperty
   a_or_file: assert property (p_or_file) else $error("or to file wrong");
   property p_mov_acc;
      isMov && !d |=> ##1 !fileWrEn && zeroFlag == (accumulator == 8'h00);
   endproperty
   a_mov_acc: assert property (p_mov_acc) else $error("move to acc wrong");
   property p_mov_file;
      isMov && d |=> ##1 fileWrEn && fileWrAddr == $past(fAddr, 2) && accumulator == $past(accumulator, 2)
         && zeroFlag == (fileWrData == 8'h00);
   endproperty
   a_mov_file: assert property (p_mov_file) else $error("move to file wrong");
endmodule
bind omie_core omie_core_chk chk (.clock(clock), .resetn(resetn), .instrWord(instrWord),
   .instrValid(instrValid), .instrReady(instrReady), .instrDone(instrDone), .unknownOp(unknownOp),
   .accumulator(accumulator), .zeroFlag(zeroFlag), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
   .fileWrData(fileWrData));

// ===== bench/omie_file_model.sv
// mirror of the file registers, used to predict results
`timescale 1ns/10ps
module omie_file_model
   import omie_pkg::*;
;
   logic [DATA_W-1:0] mem [FILE_DEPTH];
   // a written value holds until the next write to it
   task automatic put(input logic [FILE_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      mem[a] = d;
   endtask
endmodule

// ===== bench/omie_testbench.sv
// self-checking bench for the instruction executor
`timescale 1ns/10ps
module testbench
   import omie_pkg::*;
;
   typedef struct packed {
      logic [DATA_W-1:0] acc;
      logic z;
      logic we;
      logic [FILE_ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic unk;
   } omie_exp_type;
   logic clock, resetn, instrValid, busWrite, busRead, zE, rdPend;
   logic instrReady, instrDone, unknownOp, zeroFlag, fileWrEn;
   logic [INSTR_W-1:0] instrWord;
   logic [BUS_ADDR_W-1:0] busAddr;
   logic [BUS_DATA_W-1:0] busWdata, busRdata;
   logic [BUS_DATA_W-1:0] nExec, nBad;
   logic [DATA_W-1:0] accumulator, fileWrData, accE, lit;
   logic [FILE_ADDR_W-1:0] fileWrAddr;
   logic [FILE_ADDR_W-1:0] addrs [4] = '{7'h05, 7'h7F, 7'h00, 7'h40};
   int failures, totalChecks, cycles, seed;
   omie_exp_type expQ [$];
   logic [BUS_DATA_W-1:0] rdQ [$];
   always #2 clock = ~clock;
   omie_core dut (.clock(clock), .resetn(resetn), .instrWord(instrWord), .instrValid(instrValid),
      .instrReady(instrReady), .instrDone(instrDone), .unknownOp(unknownOp), .accumulator(accumulator),
      .zeroFlag(zeroFlag), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
      .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata));
   omie_file_model fm ();
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // prediction is made at issue; results of one word feed the next
   task automatic exec(input logic [INSTR_W-1:0] w);
      omie_exp_type e;
      logic [DATA_W-1:0] r;
      e = '{accE, zE, 1'b0, w[FILE_ADDR_MSB:0], 8'h00, 1'b0};
      r = (w[13:8] == OPC_OR_FILE) ? (accE | fm.mem[e.a]) : fm.mem[e.a];
      if (w[13:8] == OPC_OR_FILE || w[13:8] == OPC_MOVE_FILE)
      begin
         e.z = (r == 8'h00);
         if (w[DEST_BIT] == DEST_FILE)
            {e.we, e.d} = {1'b1, r};
         else
            e.acc = r;
      end
      else if (w[13:10] == OPC_LOAD_LIT)
         e.acc = w[LIT_MSB:0];
      else if (w[13:7] == OPC_STORE_ACC)
         {e.we, e.d} = {1'b1, accE};
      else
      begin
         e.unk = 1'b1;
         nBad = nBad + 16'h0001;
      end
      {accE, zE} = {e.acc, e.z};
      if (e.we)
         fm.put(e.a, e.d);
      nExec = nExec + 16'h0001;
      expQ.push_back(e);
      @(posedge clock);
      instrValid <= 1'b1;
      instrWord <= w;
      @(posedge clock);
      while (instrReady !== 1'b1) @(posedge clock);
      instrValid <= 1'b0;
   endtask
   task automatic bus(input logic wr, input logic [BUS_ADDR_W-1:0] a, input logic [BUS_DATA_W-1:0] v);
      @(posedge clock);
      busWrite <= wr;
      busRead <= !wr;
      busAddr <= a;
      busWdata <= v;
      if (!wr)
         rdQ.push_back(v);
   endtask
   task automatic busEnd;
      @(posedge clock);
      {busWrite, busRead} <= 2'b00;
   endtask
   always @(posedge clock)
   begin
      omie_exp_type e;
      cycles++;
      rdPend <= busRead;
      if (rdPend === 1'b1)
         chk(busRdata, rdQ.pop_front());
      if (instrDone === 1'b1)
      begin
         e = expQ.pop_front();
         chk(accumulator, e.acc);
         chk(zeroFlag, e.z);
         chk({fileWrEn, unknownOp}, {e.we, e.unk});
         if (e.we)
            chk({fileWrAddr, fileWrData}, {e.a, e.d});
      end
      if (cycles == 3000)
      begin
         failures++;
         complete_run();
      end
   end
   initial
   begin
      {clock, resetn, instrValid, busWrite, busRead, rdPend} = 6'h00;
      {instrWord, busAddr, busWdata} = '0;
      {accE, zE} = {ACC_RESET, ZERO_RESET};
      {nExec, nBad} = '0;
      {failures, totalChecks, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd80629};
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      bus(1'b0, REG_CTRL, COUNT_ONE);
      busEnd();
      foreach (addrs[i])
      begin
         lit = (i == 2) ? 8'h00 : 8'($random(seed));
         exec({OPC_LOAD_LIT, 2'b00, lit});
         exec({OPC_STORE_ACC, addrs[i]});
      end
      lit = 8'($random(seed));
      exec({OPC_LOAD_LIT, 2'b11, lit});
      bus(1'b0, REG_LASTOP, {2'b00, OPC_LOAD_LIT, 2'b00, lit});
      busEnd();
      for (int k = 0; k < 16; k++)
      begin
         if (k == 8)
            exec({OPC_LOAD_LIT, 2'b00, 8'h00});
         exec({k[0] ? OPC_MOVE_FILE : OPC_OR_FILE, k[1], addrs[k[3:2]]});
      end
      exec(14'h3FFF);
      exec(14'h0000);
      repeat (3) @(posedge clock);
      bus(1'b0, REG_ACC, {8'h00, accE});
      bus(1'b0, REG_STATUS, {15'h0000, zE});
      bus(1'b0, 8'h20, 16'h0000);
      lit = 8'($random(seed));
      bus(1'b1, REG_ACC, {8'h00, lit});
      bus(1'b1, REG_CTRL, 16'h0000);
      busEnd();
      accE = lit;
      repeat (2) @(posedge clock);
      chk(instrReady, 0);
      bus(1'b1, REG_CTRL, COUNT_ONE);
      busEnd();
      exec({OPC_STORE_ACC, 7'h11});
      exec({OPC_MOVE_FILE, 1'b0, 7'h11});
      repeat (4) @(posedge clock);
      bus(1'b0, REG_COUNT, nExec);
      bus(1'b0, REG_BADCOUNT, nBad);
      busEnd();
      // let the last read data be checked before reset clears them
      repeat (2) @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      bus(1'b0, REG_ACC, {8'h00, ACC_RESET});
      bus(1'b0, REG_STATUS, {15'h0000, ZERO_RESET});
      bus(1'b0, REG_COUNT, 16'h0000);
      busEnd();
      repeat (2) @(posedge clock);
      chk(expQ.size() + rdQ.size(), 0);
      complete_run();
   end
endmodule

// ===== hdl/omie_core.sv
// decode and execute of the four accumulator/file instructions
// Operation
// - 00 0100 d fffffff: OR accumulator with file register, update zero flag.
// - OR result goes to accumulator when d is 0, to file register when 1.
// - 00 1000 d fffffff: read file register, copy to selected destination.
// - move: d 0 loads accumulator, d 1 rewrites same file register unchanged.
// - move updates zero flag from moved value, so it tests a register.
// - 11 00xx kkkkkkkk: load literal to accumulator, ignore xx, flags unchanged.
// - 00 0000 1 fffffff: store accumulator into file register, flags unchanged.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module omie_core
   import omie_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // instruction issue
   input wire logic [INSTR_W-1:0] instrWord,
   input wire logic instrValid,
   output logic instrReady,
   // completion
   output logic instrDone,
   output logic unknownOp,
   // core state
   output logic [DATA_W-1:0] accumulator,
   output logic zeroFlag,
   // file register write observation
   output logic fileWrEn,
   output logic [FILE_ADDR_W-1:0] fileWrAddr,
   output logic [DATA_W-1:0] fileWrData,
   // register bus
   input wire logic [BUS_ADDR_W-1:0] busAddr,
   input wire logic [BUS_DATA_W-1:0] busWdata,
   input wire logic busWrite,
   input wire logic busRead,
   output logic [BUS_DATA_W-1:0] busRdata
);
   omie_state_type state_reg, state_next;
   omie_op_type op_reg, opDecoded;
   logic [FILE_ADDR_W-1:0] addr_reg, fileWa_reg;
   logic [DATA_W-1:0] lit_reg, acc_reg, fileWd_reg;
   logic [INSTR_W-1:0] lastOp_reg;
   logic [BUS_DATA_W-1:0] count_reg, badCount_reg, rdata_reg;
   logic dest_reg, ready_reg, enable_reg, zero_reg, done_reg, bad_reg, fileWe_reg;
   logic take, executing, accWe, zeroWe, memWe;
   logic [DATA_W-1:0] fileData, result, memWd, acc_next;

   assign take = instrValid && ready_reg;
   assign executing = (state_reg == ST_EXEC);

   // opcode recognition straight from the issued word
   always_comb
   begin
      opDecoded = OP_NONE;
      if (instrWord[13:8] == OPC_OR_FILE)
      begin
         opDecoded = OP_OR_ACC_FILE;
      end
      else if (instrWord[13:8] == OPC_MOVE_FILE)
      begin
         opDecoded = OP_MOVE_FILE;
      end
      else if (instrWord[13:10] == OPC_LOAD_LIT)
      begin
         opDecoded = OP_LOAD_LIT; // the two don't-care bits are not compared
      end
      else if (instrWord[13:7] == OPC_STORE_ACC)
      begin
         opDecoded = OP_STORE_ACC;
      end
   end

   // one word is taken, one execute cycle follows, then idle again
   always_comb
   begin
      case (state_reg)
         ST_IDLE:
         begin
            state_next = take ? ST_EXEC : ST_IDLE;
         end
         ST_EXEC:
         begin
            state_next = ST_IDLE; // never a second cycle, nothing skipped
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ready drops for the execute cycle so file reads never race a write-back
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ready_reg <= 1'b0;
      end
      else
      begin
         ready_reg <= enable_reg && (state_next == ST_IDLE);
      end
   end

   // latch the decoded word; operands live in fixed fields
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         op_reg <= OP_NONE;
         dest_reg <= DEST_ACC;
         addr_reg <= '0;
         lit_reg <= '0;
         lastOp_reg <= '0;
      end
      else if (take)
      begin
         op_reg <= opDecoded;
         dest_reg <= instrWord[DEST_BIT];
         addr_reg <= instrWord[FILE_ADDR_MSB:0];
         lit_reg <= instrWord[LIT_MSB:0];
         lastOp_reg <= (opDecoded == OP_LOAD_LIT) ? {instrWord[13:10], 2'b00, instrWord[LIT_MSB:0]}
            : instrWord; // don't-care bits read as zeros
      end
   end

   // file register read is launched in the take cycle, data ready in execute
   omie_file_ram #(
      .WIDTH(DATA_W),
      .DEPTH(FILE_DEPTH),
      .ADDR_W(FILE_ADDR_W)
   ) fileRam (
      .clock(clock),
      .readEn(take),
      .readAddr(instrWord[FILE_ADDR_MSB:0]),
      .readData(fileData),
      .writeEn(memWe),
      .writeAddr(addr_reg),
      .writeData(memWd)
   );

   // execute: choose result, destination and flag update
   always_comb
   begin
      result = '0;
      accWe = 1'b0;
      zeroWe = 1'b0;
      memWe = 1'b0;
      memWd = '0;
      if (executing)
      begin
         case (op_reg)
            OP_OR_ACC_FILE:
            begin
               result = acc_reg | fileData;
               zeroWe = 1'b1;
               accWe = (dest_reg == DEST_ACC);
               memWe = (dest_reg == DEST_FILE);
               memWd = result;
            end
            OP_MOVE_FILE:
            begin
               result = fileData;
               zeroWe = 1'b1;
               accWe = (dest_reg == DEST_ACC);
               memWe = (dest_reg == DEST_FILE); // same value back into same address
               memWd = fileData;
            end
            OP_LOAD_LIT:
            begin
               result = lit_reg;
               accWe = 1'b1; // zero flag left alone
            end
            OP_STORE_ACC:
            begin
               memWe = 1'b1;
               memWd = acc_reg; // no flag write enable here
            end
            default:
            begin
               result = '0;
            end
         endcase
      end
   end

   // core update wins over a software write in the same cycle
   always_comb
   begin
      acc_next = acc_reg;
      if (accWe)
      begin
         acc_next = result;
      end
      else if (busWrite && (busAddr == REG_ACC))
      begin
         acc_next = busWdata[DATA_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         acc_reg <= ACC_RESET;
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         zero_reg <= ZERO_RESET;
      end
      else if (zeroWe)
      begin
         zero_reg <= (result == '0);
      end
      else if (busWrite && (busAddr == REG_STATUS))
      begin
         zero_reg <= busWdata[STATUS_ZERO_BIT];
      end
   end

   // software can pause issue; a word already taken still completes
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         enable_reg <= CTRL_ENABLE_RESET;
      end
      else if (busWrite && (busAddr == REG_CTRL))
      begin
         enable_reg <= busWdata[CTRL_ENABLE_BIT];
      end
   end

   // completion pulses and retire counters, both wrap
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         done_reg <= 1'b0;
         bad_reg <= 1'b0;
         count_reg <= '0;
         badCount_reg <= '0;
      end
      else
      begin
         done_reg <= executing;
         bad_reg <= executing && (op_reg == OP_NONE);
         if (executing)
         begin
            count_reg <= count_reg + COUNT_ONE;
         end
         if (executing && (op_reg == OP_NONE))
         begin
            badCount_reg <= badCount_reg + COUNT_ONE;
         end
      end
   end

   // registered copy of each file write for the outside register file view
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         fileWe_reg <= 1'b0;
         fileWa_reg <= '0;
         fileWd_reg <= '0;
      end
      else
      begin
         fileWe_reg <= memWe;
         fileWa_reg <= addr_reg;
         fileWd_reg <= memWd;
      end
   end

   // read data stand for exactly one cycle, zero otherwise and when unmapped
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_reg <= '0;
      end
      else if (busRead)
      begin
         case (busAddr)
            REG_CTRL: rdata_reg <= {{(BUS_DATA_W-1){1'b0}}, enable_reg};
            REG_ACC: rdata_reg <= {{(BUS_DATA_W-DATA_W){1'b0}}, acc_reg};
            REG_STATUS: rdata_reg <= {{(BUS_DATA_W-1){1'b0}}, zero_reg};
            REG_LASTOP: rdata_reg <= {{(BUS_DATA_W-INSTR_W){1'b0}}, lastOp_reg};
            REG_COUNT: rdata_reg <= count_reg;
            REG_BADCOUNT: rdata_reg <= badCount_reg;
            default: rdata_reg <= '0;
         endcase
      end
      else
      begin
         rdata_reg <= '0;
      end
   end

   assign instrReady = ready_reg;
   assign instrDone = done_reg;
   assign unknownOp = bad_reg;
   assign accumulator = acc_reg;
   assign zeroFlag = zero_reg;
   assign fileWrEn = fileWe_reg;
   assign fileWrAddr = fileWa_reg;
   assign fileWrData = fileWd_reg;
   assign busRdata = rdata_reg;
endmodule

// ===== hdl/omie_file_ram.sv
// file register storage with registered read data
`timescale 1ns/10ps
module omie_file_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int ADDR_W = 7
)(
   // clock
   input wire logic clock,
   // read port
   input wire logic readEn,
   input wire logic [ADDR_W-1:0] readAddr,
   output logic [WIDTH-1:0] readData,
   // write port
   input wire logic writeEn,
   input wire logic [ADDR_W-1:0] writeAddr,
   input wire logic [WIDTH-1:0] writeData
);
   logic [WIDTH-1:0] mem [DEPTH];

   // no reset on the array so it maps onto plain ram
   always_ff @(posedge clock)
   begin
      if (writeEn)
      begin
         mem[writeAddr] <= writeData;
      end
   end

   always_ff @(posedge clock)
   begin
      if (readEn)
      begin
         readData <= mem[readAddr];
      end
   end
endmodule

// ===== pkg/omie_pkg.sv
// shared constants and types for the accumulator/file instruction executor
package omie_pkg;
   // word and field layout
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FILE_ADDR_W = 7;
   localparam int FILE_DEPTH = 128;
   localparam int BUS_ADDR_W = 8;
   localparam int BUS_DATA_W = 16;
   localparam int DEST_BIT = 7;
   localparam int FILE_ADDR_MSB = 6;
   localparam int LIT_MSB = 7;
   // opcode patterns, compared against the top bits of the word
   localparam logic [5:0] OPC_OR_FILE = 6'h04;
   localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
   localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
   localparam logic [6:0] OPC_STORE_ACC = 7'h01;
   // destination select values
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   // register offsets (byte addresses)
   localparam logic [BUS_ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [BUS_ADDR_W-1:0] REG_ACC = 8'h04;
   localparam logic [BUS_ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam logic [BUS_ADDR_W-1:0] REG_LASTOP = 8'h0C;
   localparam logic [BUS_ADDR_W-1:0] REG_COUNT = 8'h10;
   localparam logic [BUS_ADDR_W-1:0] REG_BADCOUNT = 8'h14;
   // field positions and reset values
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STATUS_ZERO_BIT = 0;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic [BUS_DATA_W-1:0] COUNT_ONE = 16'h0001;
   // execution states, gray along idle -> execute -> idle
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01
   } omie_state_type;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_OR_ACC_FILE = 3'b001,
      OP_MOVE_FILE = 3'b010,
      OP_LOAD_LIT = 3'b011,
      OP_STORE_ACC = 3'b100
   } omie_op_type;
endpackage
